// >>> core/flash_status_consts.svh
// constants of the flash status register block
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH
`define READ_STATUS_OPCODE 8'h05
`define BYTE1_LOCK_BIT     3'd7
`define BYTE1_FAIL_BIT     3'd5
`define BYTE1_WPPIN_BIT    3'd4
`define BYTE1_PROT_HI_BIT  3'd3
`define BYTE1_PROT_LO_BIT  3'd2
`define BYTE1_WR_EN_BIT    3'd1
`define BUSY_BIT           3'd0
`define BYTE2_RST_EN_BIT   3'd4
`define BYTE2_LOCKDN_BIT   3'd3
`define BYTE2_PROG_SUS_BIT 3'd2
`define BYTE2_ERAS_SUS_BIT 3'd1
`define BYTE1_WRITE_MASK   8'h80
`define BYTE2_WRITE_MASK   8'h18
`define LOCK_RESET         1'b0
`define RST_EN_RESET       1'b0
`define LOCKDN_RESET       1'b0
`endif

// >>> core/flash_status_pkg.sv
// types of the flash status register block
package flash_status_pkg;
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b001,
        ST_OPCODE = 3'b010,
        ST_STREAM = 3'b100
    } link_state_e;
    typedef logic [7:0] status_byte_t;
endpackage

// >>> core/flash_status_register_read.sv
// status register bank and read status command of a serial flash
// Overview of operation
// - opcode 05h under asserted chip select selects status read
// - after opcode, one status bit per following serial clock
// - after byte two, restart with byte one while selected
// - status is sampled afresh for every repeated byte
// - busy flag at bit 0 of both bytes, fresh each byte
// - status read accepted any time, even while busy
// - chip select release ends read at any bit, output floats
// - byte one bit 7 is writable lock flag, default 0
// - reserved bits read as zero and are read-only
// - byte one bit 5 reports program or erase failure
// - byte one bit 4 is 0 while write-protect pin asserted
// - byte one bits 3:2 report software protection summary
// - byte one bit 1 shows write-enable latch
// - busy bit read-only, 1 while internal operation runs
// - byte one write changes only bit 7
// - byte two bit 4 is writable soft reset enable
// - byte two bit 3 is writable lockdown command enable
// - byte two bits 2 and 1 report program and erase suspend
// - byte two write changes only bits 4 and 3
`timescale 1ns/10ps
`include "flash_status_consts.svh"
module flash_status_register_read
(
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         chipSelect_n,
    input  wire logic                         serialClock,
    input  wire logic                         serialIn,
    output logic                              serialOut,
    output logic                              serialOutEn,
    input  wire logic                         writeProtect_n,
    input  wire logic                         readyBusyFlag,
    input  wire logic                         programEraseFailFlag,
    input  wire logic [1:0]                   softProtectSummary,
    input  wire logic                         writeEnableLatch,
    input  wire logic                         programSuspendedFlag,
    input  wire logic                         eraseSuspendedFlag,
    input  wire logic                         byteOneWrite,
    input  wire flash_status_pkg::status_byte_t byteOneData,
    input  wire logic                         byteTwoWrite,
    input  wire flash_status_pkg::status_byte_t byteTwoData,
    output flash_status_pkg::status_byte_t    statusByteOne,
    output flash_status_pkg::status_byte_t    statusByteTwo,
    output logic                              softResetEnable,
    output logic                              lockdownCmdEnable,
    output logic                              protectionLockFlag
);
    import flash_status_pkg::*;

    // pin inputs cross into clk through three stages
    logic csSyncN;
    logic sckSync;
    logic mosiSync;
    logic wpSyncN;

    pin_sync #(.RESET_VAL(1'b1)) csSyncInst
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .pinIn  (chipSelect_n),
        .pinOut (csSyncN)
    );
    pin_sync #(.RESET_VAL(1'b0)) sckSyncInst
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .pinIn  (serialClock),
        .pinOut (sckSync)
    );
    pin_sync #(.RESET_VAL(1'b0)) mosiSyncInst
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .pinIn  (serialIn),
        .pinOut (mosiSync)
    );
    pin_sync #(.RESET_VAL(1'b1)) wpSyncInst
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .pinIn  (writeProtect_n),
        .pinOut (wpSyncN)
    );

    // edge detection on the filtered serial clock
    logic sckPrevReg;
    logic sckRise;
    logic sckFall;
    logic selected;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sckPrevReg <= 1'b0;
        else
            sckPrevReg <= sckSync;
    end

    assign sckRise  = sckSync & ~sckPrevReg;
    assign sckFall  = ~sckSync & sckPrevReg;
    assign selected = ~csSyncN;

    // writable fields, power-up defaults from reset
    logic lockReg;
    logic resetEnReg;
    logic lockdownEnReg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lockReg <= `LOCK_RESET;
        else if (byteOneWrite)
            lockReg <= byteOneData[`BYTE1_LOCK_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            resetEnReg    <= `RST_EN_RESET;
            lockdownEnReg <= `LOCKDN_RESET;
        end
        else if (byteTwoWrite)
        begin
            resetEnReg    <= byteTwoData[`BYTE2_RST_EN_BIT];
            lockdownEnReg <= byteTwoData[`BYTE2_LOCKDN_BIT];
        end
    end

    assign protectionLockFlag = lockReg;
    assign softResetEnable    = resetEnReg;
    assign lockdownCmdEnable  = lockdownEnReg;

    // live status composition, reserved bits tied low
    function automatic status_byte_t compose_byte_one
    (
        input logic       lock,
        input logic       fail,
        input logic       wpN,
        input logic [1:0] prot,
        input logic       wrEn,
        input logic       busy
    );
        status_byte_t b;
        b = 8'h00;
        b[`BYTE1_LOCK_BIT]    = lock;
        b[`BYTE1_FAIL_BIT]    = fail;
        b[`BYTE1_WPPIN_BIT]   = wpN;
        b[`BYTE1_PROT_HI_BIT] = prot[1];
        b[`BYTE1_PROT_LO_BIT] = prot[0];
        b[`BYTE1_WR_EN_BIT]   = wrEn;
        b[`BUSY_BIT]          = busy;
        return b;
    endfunction

    function automatic status_byte_t compose_byte_two
    (
        input logic rstEn,
        input logic lockEn,
        input logic progSus,
        input logic erasSus,
        input logic busy
    );
        status_byte_t b;
        b = 8'h00;
        b[`BYTE2_RST_EN_BIT]   = rstEn;
        b[`BYTE2_LOCKDN_BIT]   = lockEn;
        b[`BYTE2_PROG_SUS_BIT] = progSus;
        b[`BYTE2_ERAS_SUS_BIT] = erasSus;
        b[`BUSY_BIT]           = busy;
        return b;
    endfunction

    status_byte_t liveOne;
    status_byte_t liveTwo;

    assign liveOne = compose_byte_one(lockReg, programEraseFailFlag,
        wpSyncN, softProtectSummary, writeEnableLatch, readyBusyFlag);
    assign liveTwo = compose_byte_two(resetEnReg, lockdownEnReg,
        programSuspendedFlag, eraseSuspendedFlag, readyBusyFlag);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            statusByteOne <= 8'h00;
            statusByteTwo <= 8'h00;
        end
        else
        begin
            statusByteOne <= liveOne;
            statusByteTwo <= liveTwo;
        end
    end

    // link state machine
    link_state_e  stateReg;
    link_state_e  stateNext;
    logic [2:0]   bitCntReg;
    logic [7:0]   opcodeReg;
    logic         byteSelReg;
    status_byte_t shiftReg;
    logic         opcodeDone;
    logic [7:0]   opcodeFull;
    logic         ignoreReg;

    assign opcodeFull = {opcodeReg[6:0], mosiSync};
    assign opcodeDone = sckRise && (bitCntReg == 3'd7);

    always_comb
    begin
        stateNext = stateReg;
        case (stateReg)
            ST_IDLE:
                if (selected && !ignoreReg)
                    stateNext = ST_OPCODE;
            ST_OPCODE:
                if (!selected)
                    stateNext = ST_IDLE;
                else if (opcodeDone && opcodeFull == `READ_STATUS_OPCODE)
                    stateNext = ST_STREAM;
                else if (opcodeDone)
                    stateNext = ST_IDLE;
            ST_STREAM:
                if (!selected)
                    stateNext = ST_IDLE;
            default:
                stateNext = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stateReg <= ST_IDLE;
        else
            stateReg <= stateNext;
    end

    // foreign opcodes park in idle until chip select drops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ignoreReg <= 1'b0;
        else if (!selected)
            ignoreReg <= 1'b0;
        else if (stateReg == ST_OPCODE && opcodeDone
                 && opcodeFull != `READ_STATUS_OPCODE)
            ignoreReg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bitCntReg <= 3'd0;
            opcodeReg <= 8'h00;
        end
        else if (!selected || stateReg == ST_IDLE)
        begin
            bitCntReg <= 3'd0;
            opcodeReg <= 8'h00;
        end
        else if (stateReg == ST_OPCODE && sckRise)
        begin
            bitCntReg <= bitCntReg + 3'd1;
            opcodeReg <= opcodeFull;
        end
    end

    logic [2:0] outCntReg;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            outCntReg  <= 3'd0;
            byteSelReg <= 1'b0;
            shiftReg   <= 8'h00;
        end
        else if (stateReg != ST_STREAM || !selected)
        begin
            outCntReg  <= 3'd0;
            byteSelReg <= 1'b0;
        end
        else if (sckFall)
        begin
            // fresh sample at each byte start, msb leaves first
            if (outCntReg == 3'd0)
            begin
                shiftReg   <= byteSelReg ? liveTwo : liveOne;
                byteSelReg <= ~byteSelReg;
            end
            else
            begin
                shiftReg <= {shiftReg[6:0], 1'b0};
            end
            outCntReg <= outCntReg + 3'd1;
        end
    end

    // output driven from the first falling edge after the opcode
    logic driveReg;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            driveReg <= 1'b0;
        else if (stateReg != ST_STREAM || !selected || ignoreReg)
            driveReg <= 1'b0;
        else if (sckFall)
            driveReg <= 1'b1;
    end

    assign serialOut   = driveReg ? shiftReg[7] : 1'b0;
    assign serialOutEn = driveReg;

    // byte one bit 6 and byte two bits 7:5 stay low
    reserved_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        statusByteOne[6] == 1'b0 && statusByteTwo[7:5] == 3'b000)
        else $error("reserved status bits not zero");

    busy_both_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        statusByteOne[0] == statusByteTwo[0])
        else $error("busy flag differs between bytes");

    release_float_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !selected |=> !serialOutEn)
        else $error("output driven after release");

    lock_write_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        byteOneWrite |=> lockReg == $past(byteOneData[7]))
        else $error("lock bit not written");

    enable_write_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        byteTwoWrite |=> {resetEnReg, lockdownEnReg}
            == $past(byteTwoData[4:3]))
        else $error("enable bits not written");

    wp_follow_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> statusByteOne[4] == $past(wpSyncN))
        else $error("write-protect bit stale");

    opcode_start_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (stateReg == ST_OPCODE && selected && opcodeDone
         && opcodeFull == 8'h05) |=> stateReg == ST_STREAM)
        else $error("read opcode not recognised");

    no_drive_early_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        stateReg != ST_STREAM |=> !serialOutEn)
        else $error("output driven before opcode done");

    shift_change_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (driveReg && !sckFall && stateReg == ST_STREAM)
            |=> $stable(shiftReg))
        else $error("output changed off falling edge");
endmodule

// >>> core/pin_sync.sv
// three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/10ps
module pin_sync
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pinIn,
    output logic      pinOut
);
    logic s1Reg;
    logic s2Reg;
    logic s3Reg;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1Reg <= RESET_VAL;
            s2Reg <= RESET_VAL;
            s3Reg <= RESET_VAL;
        end
        else
        begin
            s1Reg <= pinIn;
            s2Reg <= s1Reg;
            s3Reg <= s2Reg;
        end
    end
    // change only counts once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pinOut <= RESET_VAL;
        else if (s2Reg == s3Reg)
            pinOut <= s3Reg;
    end
endmodule

// >>> testbench/spi_host_model.sv
// host serial controller model driving status read frames
`timescale 1ns/10ps
module spi_host_model
(
    input  wire logic clk,
    input  wire logic serialWire,
    output logic      chipSelect_n,
    output logic      serialClock,
    output logic      serialIn,
    output int        bitCount
);
    initial
    begin
        chipSelect_n = 1'b1;
        serialClock = 1'b0;
        serialIn = 1'b0;
        bitCount = 0;
    end

    // link runs at 800 ns, below the limit, so no byte is dropped
    task automatic halfBit();
        repeat (4) @(negedge clk);
    endtask

    // opcode msb first, clock idles low between frames
    task automatic frame(input logic [7:0] opcode, input int nBits,
                         output logic [31:0] got);
        got = '0;
        bitCount = 0;
        chipSelect_n = 1'b0;
        halfBit();
        for (int i = 0; i < 8 + nBits; i++)
        begin
            // data phase toggles the input so a stale value never helps
            serialIn = (i < 8) ? opcode[7 - i] : ~serialIn;
            halfBit();
            serialClock = 1'b1;
            halfBit();
            // late capture: the pin sync delays the output several cycles
            if (i >= 8)
            begin
                got = {got[30:0], serialWire};
                bitCount = i - 7;
            end
            serialClock = 1'b0;
        end
        halfBit();
        chipSelect_n = 1'b1;
        serialIn = ~serialIn;
    endtask
endmodule

// >>> testbench/test_flash_status_register_read.sv
// self-checking bench for the status register read block
`timescale 1ns/10ps
module test_flash_status_register_read;
    import flash_status_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         chipSelect_n, serialClock, serialIn;
    logic         serialOut, serialOutEn, soWire, lastSo = 1'b0;
    logic         wpN = 1'b1, busy = 1'b0, fail = 1'b0, wrEnable = 1'b0;
    logic [1:0]   protSum = 2'b11;
    logic         progSusp = 1'b0, eraseSusp = 1'b0, enSeen = 1'b0;
    logic         wrOne = 1'b0, wrTwo = 1'b0;
    status_byte_t dataOne = 8'h00, dataTwo = 8'h00;
    status_byte_t byteOne, byteTwo;
    logic         resetEnOut, lockdnOut, lockOut;
    logic [31:0]  got;
    int           bitCount, errCount = 0, numChecks = 0;
    logic [7:0]   badOps [4] = '{8'h06, 8'h9F, 8'h04, 8'h85};
    logic [1:0]   protTab [4] = '{2'b00, 2'b01, 2'b11, 2'b00};

    always #50 clk = ~clk;
    // released line: show the inverse so a stale bit cannot match
    always @(posedge clk) if (serialOutEn) lastSo <= serialOut;
    assign soWire = serialOutEn ? serialOut : ~lastSo;
    always @(posedge clk) if (serialOutEn === 1'b1) enSeen = 1'b1;

    flash_status_register_read flash_status_register_read_inst
    (
        .clk                  (clk),
        .rst_n                (rst_n),
        .chipSelect_n         (chipSelect_n),
        .serialClock          (serialClock),
        .serialIn             (serialIn),
        .serialOut            (serialOut),
        .serialOutEn          (serialOutEn),
        .writeProtect_n       (wpN),
        .readyBusyFlag        (busy),
        .programEraseFailFlag (fail),
        .softProtectSummary   (protSum),
        .writeEnableLatch     (wrEnable),
        .programSuspendedFlag (progSusp),
        .eraseSuspendedFlag   (eraseSusp),
        .byteOneWrite         (wrOne),
        .byteOneData          (dataOne),
        .byteTwoWrite         (wrTwo),
        .byteTwoData          (dataTwo),
        .statusByteOne        (byteOne),
        .statusByteTwo        (byteTwo),
        .softResetEnable      (resetEnOut),
        .lockdownCmdEnable    (lockdnOut),
        .protectionLockFlag   (lockOut)
    );

    spi_host_model host_inst
    (
        .clk          (clk),
        .serialWire   (soWire),
        .chipSelect_n (chipSelect_n),
        .serialClock  (serialClock),
        .serialIn     (serialIn),
        .bitCount     (bitCount)
    );

    function automatic status_byte_t expOne(input logic lock);
        return {lock, 1'b0, fail, wpN, protSum, wrEnable, busy};
    endfunction

    function automatic status_byte_t expTwo(input logic rstEn, lockEn);
        return {3'b000, rstEn, lockEn, progSusp, eraseSusp, busy};
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic checkByte(input string what, input status_byte_t e, g);
        numChecks++;
        if (g !== e)
        begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic checkFlag(input string what, input logic e, g);
        numChecks++;
        if (g !== e)
        begin
            errCount++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic checkStream(input string what, input logic [31:0] e, g);
        numChecks++;
        if (g !== e)
        begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic settle();
        repeat (6) @(negedge clk);
    endtask

    task automatic writeByte(input logic two, input status_byte_t d);
        @(negedge clk);
        wrOne = ~two;
        wrTwo = two;
        dataOne = d;
        dataTwo = d;
        @(negedge clk);
        wrOne = 1'b0;
        wrTwo = 1'b0;
        settle();
    endtask

    task automatic checkRegs(input logic lock, rstEn, lockEn);
        checkByte("byte one", expOne(lock), byteOne);
        checkByte("byte two", expTwo(rstEn, lockEn), byteTwo);
        checkFlag("lock flag", lock, lockOut);
        checkFlag("reset enable", rstEn, resetEnOut);
        checkFlag("lockdown enable", lockEn, lockdnOut);
    endtask

    initial
    begin
        #2_000_000;
        errCount++;
        $display("MISMATCH watchdog expected done seen hang");
        summarize();
    end

    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        settle();
        checkRegs(1'b0, 1'b0, 1'b0);
        writeByte(1'b0, 8'h7F);
        checkRegs(1'b0, 1'b0, 1'b0);
        writeByte(1'b0, 8'h80);
        checkRegs(1'b1, 1'b0, 1'b0);
        writeByte(1'b1, 8'hE7);
        checkRegs(1'b1, 1'b0, 1'b0);
        writeByte(1'b1, 8'h10);
        checkRegs(1'b1, 1'b1, 1'b0);
        writeByte(1'b1, 8'h08);
        checkRegs(1'b1, 1'b0, 1'b1);
        // live fields follow their inputs, reserved bits stay zero
        for (int i = 0; i < 8; i++)
        begin
            fail = i[0];
            wpN = ~i[0];
            wrEnable = i[1];
            busy = i[2];
            progSusp = i[1];
            eraseSusp = i[2] ^ i[0];
            protSum = protTab[i[1:0]];
            settle();
            checkRegs(1'b1, 1'b0, 1'b1);
            checkByte("field mix", expTwo(0, 1), byteTwo);
        end
        wrEnable = 1'b1;
        protSum = 2'b01;
        busy = 1'b1;
        settle();
        // busy falls mid-stream while the host keeps polling
        fork
            host_inst.frame(8'h05, 32, got);
            begin
                wait (bitCount == 12);
                busy = 1'b0;
            end
        join
        checkStream("stream", {expOne(1) | 8'h01, expTwo(0, 1) | 8'h01,
            expOne(1), expTwo(0, 1)}, got);
        // release takes the pin sync latency to reach the enable
        settle();
        checkFlag("released", 1'b0, serialOutEn);
        // other opcodes, some one bit off, never drive the output
        foreach (badOps[k])
        begin
            enSeen = 1'b0;
            host_inst.frame(badOps[k], 16, got);
            settle();
            checkFlag("refused drive", 1'b0, enSeen);
        end
        enSeen = 1'b0;
        host_inst.frame(8'h05, 5, got);
        settle();
        checkFlag("partial drive", 1'b1, enSeen);
        checkFlag("partial release", 1'b0, serialOutEn);
        checkByte("partial bits", expOne(1'b1) >> 3,
            {3'b000, got[4:0]});
        summarize();
    end
endmodule
